/* hw/ced_consts.svh */
`ifndef CED_CONSTS_SVH
`define CED_CONSTS_SVH

// ==========================================================================
// Register byte offsets
`define CED_OFF_CTRL        12'h000
`define CED_OFF_IE          12'h004
`define CED_OFF_ISTAT       12'h008
`define CED_OFF_IMASK       12'h00c
`define CED_OFF_STATE       12'h010

// ==========================================================================
// Field positions and widths
`define CED_CTRL_MODE_LSB   0
`define CED_CTRL_EN_BIT     3
`define CED_CTRL_FLAG_BIT   4
`define CED_IE_CMP_BIT      6
`define CED_IE_W            8
`define CED_IRQ_W           2
`define CED_IRQ_EVENT_BIT   0
`define CED_IRQ_REJECT_BIT  1

// ==========================================================================
// Reset values
`define CED_MODE_RST        3'h0
`define CED_IE_RST          8'h00
`define CED_IMASK_RST       2'h0

// ==========================================================================
// Timing
`define CED_CLK_MHZ         40
`define CED_SETTLE_US       10
`define CED_SETTLE_CYC      ((`CED_SETTLE_US) * (`CED_CLK_MHZ))
`define CED_CLKS_PER_MCYCLE 12
`define CED_S4_INDEX        7

`endif

/* hw/ced_pkg.sv */
package ced_pkg;

  typedef enum logic [2:0] {
    CED_MODE_LOW     = 3'h0,
    CED_MODE_RISE    = 3'h1,
    CED_MODE_DB_TOG  = 3'h2,
    CED_MODE_DB_RISE = 3'h3,
    CED_MODE_FALL    = 3'h4,
    CED_MODE_TOG     = 3'h5,
    CED_MODE_DB_FALL = 3'h6,
    CED_MODE_HIGH    = 3'h7
  } ced_mode_t;

  typedef enum logic [1:0] {
    CED_DB_IDLE  = 2'h0,
    CED_DB_WAIT1 = 2'h1,
    CED_DB_WAIT2 = 2'h2,
    CED_DB_CHECK = 2'h3
  } ced_db_state_t;

endpackage

/* hw/ced_smp_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface ced_smp_if;
  logic run;
  logic strobe;
  logic cur;
  logic prev;
  modport src (input run, output strobe, output cur, output prev);
  modport snk (output run, input strobe, input cur, input prev);
endinterface
`default_nettype wire

/* hw/ced_sampler.sv */
`timescale 1ns/100ps
`default_nettype none
`include "ced_consts.svh"
module ced_sampler
  import ced_pkg::*;
#(
  parameter int CLKS_PER_MCYCLE = `CED_CLKS_PER_MCYCLE,
  parameter int S4_INDEX        = `CED_S4_INDEX
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic comparator_raw,
  ced_smp_if.src    smp
);

  localparam int CW = $clog2(CLKS_PER_MCYCLE);

  if (CLKS_PER_MCYCLE < 2 || S4_INDEX >= CLKS_PER_MCYCLE) begin : g_bad_cfg
    $error("ced_sampler: fourth state index outside the machine cycle");
  end

  logic          sync1_reg;
  logic          sync2_reg;
  logic [CW-1:0] phase_reg;
  logic          strobe_reg;
  logic          cur_reg;
  logic          prev_reg;

  // ========================================================================
  // Synchronizer: the comparator output is asynchronous to pclk.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end else begin
      sync1_reg <= comparator_raw;
      sync2_reg <= sync1_reg;
    end
  end

  // ========================================================================
  // Machine cycle phase counter, free running.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_reg <= '0;
    end else if (phase_reg == CW'(CLKS_PER_MCYCLE - 1)) begin
      phase_reg <= '0;
    end else begin
      phase_reg <= phase_reg + CW'(1);
    end
  end

  // ========================================================================
  // Sample at the fourth state phase; the result is held low while not running.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strobe_reg <= 1'b0;
      cur_reg    <= 1'b0;
      prev_reg   <= 1'b0;
    end else if (!smp.run) begin
      strobe_reg <= 1'b0;
      cur_reg    <= 1'b0;
      prev_reg   <= 1'b0;
    end else if (phase_reg == CW'(S4_INDEX)) begin
      strobe_reg <= 1'b1;
      cur_reg    <= sync2_reg;
      prev_reg   <= cur_reg;
    end else begin
      strobe_reg <= 1'b0;
    end
  end

  assign smp.strobe = strobe_reg;
  assign smp.cur    = cur_reg;
  assign smp.prev   = prev_reg;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  strobe_space_a: assert property (smp.strobe |=> (!smp.strobe) [*8])
    else $error("sample strobe came sooner than once per machine cycle");
  result_low_a: assert property (!smp.run |=> !smp.cur && !smp.strobe)
    else $error("result not forced low while stopped");

endmodule
`default_nettype wire

/* hw/ced_top.sv */
`timescale 1ns/100ps
`default_nettype none
`include "ced_consts.svh"
module ced_top
  import ced_pkg::*;
#(
  parameter int ADDR_W          = 12,
  parameter int CLKS_PER_MCYCLE = `CED_CLKS_PER_MCYCLE,
  parameter int S4_INDEX        = `CED_S4_INDEX
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              comparator_raw,
  input  wire logic              timer1_overflow,
  input  wire logic              idle_mode,
  input  wire logic              power_down_mode,
  output logic                   irq
);

  localparam int SETTLE_CYC = `CED_SETTLE_CYC;
  localparam int SW         = $clog2(SETTLE_CYC + 1);

  if (ADDR_W < 5) begin : g_bad_addr
    $error("ced_top: address too narrow for the register map");
  end

  // ========================================================================
  // Condition decoding, shared by the plain and the debounced paths.
  function automatic logic is_debounced(input logic [2:0] m);
    return (m == CED_MODE_DB_TOG) || (m == CED_MODE_DB_RISE) || (m == CED_MODE_DB_FALL);
  endfunction

  function automatic logic event_cond(input logic [2:0] m, input logic c, input logic p);
    case (m)
      CED_MODE_LOW:     return !c;
      CED_MODE_HIGH:    return c;
      CED_MODE_RISE,
      CED_MODE_DB_RISE: return c && !p;
      CED_MODE_FALL,
      CED_MODE_DB_FALL: return !c && p;
      CED_MODE_TOG,
      CED_MODE_DB_TOG:  return c != p;
      default:          return 1'b0;
    endcase
  endfunction

  ced_smp_if smp ();

  logic [2:0]              mode_reg;
  logic                    en_reg;
  logic                    flag_reg;
  logic                    flag_next;
  logic [`CED_IE_W-1:0]    ie_reg;
  logic [`CED_IRQ_W-1:0]   istat_reg;
  logic [`CED_IRQ_W-1:0]   istat_next;
  logic [`CED_IRQ_W-1:0]   imask_reg;
  logic [SW-1:0]           settle_reg;
  ced_db_state_t           db_state_reg;
  logic                    expect_reg;
  logic [31:0]             prdata_reg;
  logic                    pready_reg;
  logic                    pslverr_reg;
  logic                    irq_reg;
  logic                    run;
  logic                    plain_hit;
  logic                    db_trig;
  logic                    db_hit;
  logic                    db_rej;
  logic                    set_evt;
  logic                    acc;
  logic                    done;
  logic                    wr_ctrl;
  logic                    rd_istat;
  logic                    mapped;
  logic [31:0]             rdata;

  ced_sampler #(
    .CLKS_PER_MCYCLE (CLKS_PER_MCYCLE),
    .S4_INDEX        (S4_INDEX)
  ) u_sampler (
    .pclk           (pclk),
    .presetn        (presetn),
    .comparator_raw (comparator_raw),
    .smp            (smp)
  );

  // ========================================================================
  // Run gate and event detection. The strobe is registered, so it can still
  // be high in the cycle in which the gate drops; run is checked again here.
  assign run       = en_reg && !idle_mode && !power_down_mode;
  assign smp.run   = run;
  assign plain_hit = smp.strobe && run && !is_debounced(mode_reg)
                   && event_cond(mode_reg, smp.cur, smp.prev);
  assign db_trig   = smp.strobe && run && is_debounced(mode_reg)
                   && event_cond(mode_reg, smp.cur, smp.prev);
  assign db_hit    = (db_state_reg == CED_DB_CHECK) && smp.strobe && run
                   && (smp.cur == expect_reg);
  assign db_rej    = (db_state_reg == CED_DB_CHECK) && smp.strobe && run
                   && (smp.cur != expect_reg);
  assign set_evt   = plain_hit || db_hit;

  // ========================================================================
  // Debounce sequencer: the timer runs freely, so two overflows guarantee at
  // least one full period before the resample.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      db_state_reg <= CED_DB_IDLE;
      expect_reg   <= 1'b0;
    end else if (!run || !is_debounced(mode_reg)) begin
      db_state_reg <= CED_DB_IDLE;
    end else begin
      case (db_state_reg)
        CED_DB_IDLE: begin
          if (db_trig) begin
            db_state_reg <= CED_DB_WAIT1;
            expect_reg   <= smp.cur;
          end
        end
        CED_DB_WAIT1: begin
          if (timer1_overflow) begin
            db_state_reg <= CED_DB_WAIT2;
          end
        end
        CED_DB_WAIT2: begin
          if (timer1_overflow) begin
            db_state_reg <= CED_DB_CHECK;
          end
        end
        CED_DB_CHECK: begin
          if (smp.strobe) begin
            db_state_reg <= CED_DB_IDLE;
          end
        end
        default: begin
          db_state_reg <= CED_DB_IDLE;
        end
      endcase
    end
  end

  // ========================================================================
  // APB slave with one wait state; read data is captured at the wait-state edge, while writes and read clears act on the completing edge.
  assign acc      = psel && penable;
  assign done     = acc && pready_reg;
  assign mapped   = (paddr == ADDR_W'(`CED_OFF_CTRL)) || (paddr == ADDR_W'(`CED_OFF_IE))
                 || (paddr == ADDR_W'(`CED_OFF_ISTAT)) || (paddr == ADDR_W'(`CED_OFF_IMASK))
                 || (paddr == ADDR_W'(`CED_OFF_STATE));
  assign wr_ctrl  = done && pwrite && (paddr == ADDR_W'(`CED_OFF_CTRL));
  assign rd_istat = done && !pwrite && (paddr == ADDR_W'(`CED_OFF_ISTAT));

  always_comb begin
    rdata = 32'h0000_0000;
    case (paddr)
      ADDR_W'(`CED_OFF_CTRL): begin
        rdata[`CED_CTRL_MODE_LSB +: 3] = mode_reg;
        rdata[`CED_CTRL_EN_BIT]        = en_reg;
        rdata[`CED_CTRL_FLAG_BIT]      = flag_reg;
      end
      ADDR_W'(`CED_OFF_IE):    rdata[`CED_IE_W-1:0]  = ie_reg;
      ADDR_W'(`CED_OFF_ISTAT): rdata[`CED_IRQ_W-1:0] = istat_reg;
      ADDR_W'(`CED_OFF_IMASK): rdata[`CED_IRQ_W-1:0] = imask_reg;
      ADDR_W'(`CED_OFF_STATE): begin
        rdata[0] = smp.cur;
        rdata[1] = en_reg && (settle_reg == SW'(SETTLE_CYC));
      end
      default: rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end else if (acc && !pready_reg) begin
      pready_reg  <= 1'b1;
      pslverr_reg <= !mapped;
      prdata_reg  <= pwrite ? 32'h0000_0000 : rdata;
    end else begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end
  end

  // ========================================================================
  // Configuration registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg  <= `CED_MODE_RST;
      en_reg    <= 1'b0;
      ie_reg    <= `CED_IE_RST;
      imask_reg <= `CED_IMASK_RST;
    end else if (done && pwrite) begin
      if (paddr == ADDR_W'(`CED_OFF_CTRL)) begin
        mode_reg <= pwdata[`CED_CTRL_MODE_LSB +: 3];
        en_reg   <= pwdata[`CED_CTRL_EN_BIT];
      end
      if (paddr == ADDR_W'(`CED_OFF_IE)) begin
        ie_reg <= pwdata[`CED_IE_W-1:0];
      end
      if (paddr == ADDR_W'(`CED_OFF_IMASK)) begin
        imask_reg <= pwdata[`CED_IRQ_W-1:0];
      end
    end
  end

  // Settling timer: gives software a readable sign that the analog output
  // has had time to settle after enabling.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      settle_reg <= '0;
    end else if (!en_reg) begin
      settle_reg <= '0;
    end else if (settle_reg != SW'(SETTLE_CYC)) begin
      settle_reg <= settle_reg + SW'(1);
    end
  end

  // ========================================================================
  // Event flag: writing zero clears it, writing one leaves it; a new event in
  // the clearing cycle wins so that no event is lost.
  always_comb begin
    flag_next = flag_reg;
    if (wr_ctrl && !pwdata[`CED_CTRL_FLAG_BIT]) begin
      flag_next = 1'b0;
    end
    if (set_evt) begin
      flag_next = 1'b1;
    end
  end

  always_comb begin
    // Only the bits returned by the read are cleared, so an event that lands
    // between the data capture and the completing edge is not lost.
    istat_next = rd_istat ? (istat_reg & ~prdata_reg[`CED_IRQ_W-1:0]) : istat_reg;
    istat_next[`CED_IRQ_EVENT_BIT]  = istat_next[`CED_IRQ_EVENT_BIT] | set_evt;
    istat_next[`CED_IRQ_REJECT_BIT] = istat_next[`CED_IRQ_REJECT_BIT] | db_rej;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_reg  <= 1'b0;
      istat_reg <= '0;
      irq_reg   <= 1'b0;
    end else begin
      flag_reg  <= flag_next;
      istat_reg <= istat_next;
      irq_reg   <= (flag_next && ie_reg[`CED_IE_CMP_BIT])
                 || |(istat_next & imask_reg);
    end
  end

  assign prdata  = prdata_reg;
  assign pready  = pready_reg;
  assign pslverr = pslverr_reg;
  assign irq     = irq_reg;

  // ========================================================================
  // Checks.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_db_armed;
    db_state_reg == CED_DB_IDLE && db_trig && run;
  endsequence

  sequence s_two_ovf;
    (db_state_reg == CED_DB_WAIT1) ##0 timer1_overflow && run && is_debounced(mode_reg)
    ##1 (db_state_reg == CED_DB_WAIT2);
  endsequence

  flag_set_a: assert property (plain_hit |=> flag_reg)
    else $error("plain condition met but flag not set");
  flag_hold_a: assert property (flag_reg && !wr_ctrl |=> flag_reg)
    else $error("flag dropped without a software clear");
  off_no_set_a: assert property (!run && !flag_reg |=> !flag_reg)
    else $error("flag set while comparator not running");
  idle_no_set_a: assert property ((idle_mode || power_down_mode) |-> !set_evt)
    else $error("event raised in idle or power-down");
  db_arm_a: assert property (s_db_armed |=> db_state_reg == CED_DB_WAIT1 && expect_reg == $past(smp.cur))
    else $error("debounce did not arm on a relevant transition");
  db_wait_a: assert property (s_two_ovf |-> !set_evt)
    else $error("debounce step out of order");
  db_early_a: assert property (db_state_reg != CED_DB_CHECK |-> !db_hit && !db_rej)
    else $error("debounced event resolved before two overflows");
  db_reject_a: assert property (db_rej && !plain_hit && !wr_ctrl |=> flag_reg == $past(flag_reg))
    else $error("rejected debounce changed the flag");
  db_accept_a: assert property (db_hit |=> flag_reg)
    else $error("agreeing resample did not set the flag");
  irq_gate_a: assert property (flag_reg && ie_reg[`CED_IE_CMP_BIT]
                               && $past(ie_reg[`CED_IE_CMP_BIT]) |-> irq_reg)
    else $error("interrupt missing while flag set and enabled");
  irq_quiet_a: assert property (!flag_reg && istat_reg == '0 |-> !irq_reg)
    else $error("interrupt high with nothing pending");

endmodule
`default_nettype wire

/* tb/ced_far_model.sv */
`timescale 1ns/100ps
`default_nettype none
// ==========================================================================
// Comparator front end and free-running Timer 1 stand-in.
module ced_far_model #(
  parameter int TIMER_PERIOD = 100
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [15:0] pos_level,
  input  wire logic [15:0] neg_level,
  output logic             comparator_raw,
  output logic             timer1_overflow
);
  int cnt;

  assign comparator_raw = (pos_level > neg_level);

  // The timer never stops, so a debounced event lands one to two periods late.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 0;
      timer1_overflow <= 1'b0;
    end else begin
      cnt <= (cnt == TIMER_PERIOD - 1) ? 0 : cnt + 1;
      timer1_overflow <= (cnt == TIMER_PERIOD - 1);
    end
  end
endmodule
`default_nettype wire

/* tb/tb.sv */
`timescale 1ns/100ps
`default_nettype none
`include "ced_consts.svh"
module tb
  import ced_pkg::*;
  ;
  localparam int TP = 100;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic        comparator_raw;
  logic        timer1_overflow;
  logic        idle_mode;
  logic        power_down_mode;
  logic [15:0] pos_level;
  logic [15:0] neg_level;
  int          bad_count;
  int          checks;

  ced_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .comparator_raw(comparator_raw), .timer1_overflow(timer1_overflow),
    .idle_mode(idle_mode), .power_down_mode(power_down_mode), .irq(irq));

  ced_far_model #(.TIMER_PERIOD(TP)) i_far (.pclk(pclk), .presetn(presetn),
    .pos_level(pos_level), .neg_level(neg_level), .comparator_raw(comparator_raw),
    .timer1_overflow(timer1_overflow));

  always #12.5 pclk = ~pclk;

  // ==========================================================================
  // Bus and check helpers
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rc(input string name, input logic [11:0] a, input logic [31:0] m,
                    input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(name, exp, r & m);
    chk("slverr", 32'h0, {31'h0, e});
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic cmp(input logic v);
    @(posedge pclk);
    pos_level <= v ? 16'h0200 : 16'h0100;
  endtask

  task automatic flag(input logic f);
    rc("flag", `CED_OFF_CTRL, 32'h10, {27'h0, f, 4'h0});
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // Tests
  initial begin
    logic [31:0] r;
    logic        e;
    ced_mode_t   pm [5];
    ced_mode_t   dm [3];
    logic [4:0]  ps;
    logic [4:0]  hold;
    logic [4:0]  back;
    logic [2:0]  ds;
    pm = '{CED_MODE_LOW, CED_MODE_RISE, CED_MODE_FALL, CED_MODE_TOG, CED_MODE_HIGH};
    dm = '{CED_MODE_DB_RISE, CED_MODE_DB_FALL, CED_MODE_DB_TOG};
    ps = 5'b00101;
    hold = 5'b10001;
    back = 5'b11001;
    ds = 3'b010;
    {pclk, presetn, psel, penable, pwrite, idle_mode, power_down_mode} = '0;
    paddr = '0;
    pwdata = '0;
    pos_level = 16'h0100;
    neg_level = 16'h0180;
    bad_count = 0;
    checks = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rc("ctrl", `CED_OFF_CTRL, 32'hffffffff, 32'h0);
    rc("int_enable", `CED_OFF_IE, 32'hffffffff, 32'h0);
    rc("istat", `CED_OFF_ISTAT, 32'hffffffff, 32'h0);
    rc("imask", `CED_OFF_IMASK, 32'hffffffff, 32'h0);
    chk("irq", 32'h0, {31'h0, irq});
    apb(1'b0, 12'h020, 32'h0, r, e);
    chk("slverr", 32'h1, {31'h0, e});
    cmp(1'b1);
    wr(`CED_OFF_CTRL, {29'h0, CED_MODE_HIGH});
    cyc(40);
    flag(1'b0);
    rc("state", `CED_OFF_STATE, 32'h1, 32'h0);
    wr(`CED_OFF_CTRL, {28'h1, CED_MODE_HIGH});
    cyc(40);
    rc("state", `CED_OFF_STATE, 32'h3, 32'h1);
    flag(1'b1);
    // Each plain mode: quiet start, trigger, clear while held, return.
    for (int i = 0; i < 5; i++) begin
      cmp(ps[i]);
      wr(`CED_OFF_CTRL, {28'h1, pm[i]});
      cyc(40);
      wr(`CED_OFF_CTRL, {28'h1, pm[i]});
      cyc(40);
      flag(1'b0);
      cmp(~ps[i]);
      cyc(40);
      flag(1'b1);
      wr(`CED_OFF_CTRL, {28'h1, pm[i]});
      cyc(40);
      flag(hold[i]);
      cmp(ps[i]);
      cyc(40);
      flag(back[i]);
    end
    // Interrupt gating, sticky status and mask.
    cmp(1'b0);
    wr(`CED_OFF_CTRL, {28'h1, CED_MODE_HIGH});
    cyc(40);
    apb(1'b0, `CED_OFF_ISTAT, 32'h0, r, e);
    cmp(1'b1);
    cyc(40);
    chk("irq", 32'h0, {31'h0, irq});
    flag(1'b1);
    rc("settled", `CED_OFF_STATE, 32'h2, 32'h2);
    wr(`CED_OFF_CTRL, {28'h1, CED_MODE_HIGH});
    wr(`CED_OFF_IE, 32'h40);
    rc("int_enable", `CED_OFF_IE, 32'hff, 32'h40);
    chk("irq", 32'h1, {31'h0, irq});
    wr(`CED_OFF_IE, 32'h0);
    cyc(3);
    chk("irq", 32'h0, {31'h0, irq});
    wr(`CED_OFF_IMASK, 32'h1);
    rc("imask", `CED_OFF_IMASK, 32'h3, 32'h1);
    chk("irq", 32'h1, {31'h0, irq});
    cmp(1'b0);
    cyc(40);
    rc("istat", `CED_OFF_ISTAT, 32'h3, 32'h1);
    cyc(3);
    chk("irq", 32'h0, {31'h0, irq});
    rc("istat", `CED_OFF_ISTAT, 32'h3, 32'h0);
    // Idle, then power-down, must both hold events off.
    wr(`CED_OFF_CTRL, {28'h1, CED_MODE_HIGH});
    for (int j = 0; j < 2; j++) begin
      @(posedge pclk);
      idle_mode <= (j == 0);
      power_down_mode <= (j == 1);
      cmp(1'b1);
      cyc(40);
      flag(1'b0);
      @(posedge pclk);
      idle_mode <= 1'b0;
      power_down_mode <= 1'b0;
      cyc(40);
      flag(1'b1);
      cmp(1'b0);
      cyc(40);
      wr(`CED_OFF_CTRL, {28'h1, CED_MODE_HIGH});
    end
    // Debounced modes: still nothing at half a timer period, flagged two periods and 40 cycles after that.
    for (int k = 0; k < 3; k++) begin
      cmp(ds[k]);
      wr(`CED_OFF_CTRL, {28'h1, dm[k]});
      cyc(40);
      wr(`CED_OFF_CTRL, {28'h1, dm[k]});
      apb(1'b0, `CED_OFF_ISTAT, 32'h0, r, e);
      cmp(~ds[k]);
      cyc(TP / 2);
      flag(1'b0);
      cyc(2 * TP + 40);
      flag(1'b1);
    end
    // A short dip must be rejected after the resample.
    wr(`CED_OFF_CTRL, {28'h1, CED_MODE_DB_FALL});
    cyc(40);
    wr(`CED_OFF_CTRL, {28'h1, CED_MODE_DB_FALL});
    apb(1'b0, `CED_OFF_ISTAT, 32'h0, r, e);
    cmp(1'b0);
    cyc(20);
    cmp(1'b1);
    cyc(2 * TP + 60);
    flag(1'b0);
    rc("istat", `CED_OFF_ISTAT, 32'h3, 32'h2);
    final_report();
  end

  // The tests take a few thousand cycles; this cuts a hang short.
  initial begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    final_report();
  end
endmodule
`default_nettype wire
